// ===== core/periodic_wakeup_timebase.sv
// periodic wakeup timebase: control register, crystal edge detection,
// power-mode gating and the interrupt request level.
// assumes all inputs are synchronous to clk_in, including the crystal clock
// which is far slower than clk_in and only sampled here.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1: rollover at selected tap sets read-only flag
// RULE2: enabled rollover raises CPU interrupt request
// RULE3: writing one to acknowledge clears flag
// RULE4: acknowledge bit always reads back zero
// RULE5: writing zero to acknowledge changes nothing
// RULE6: rate code selects divider 32768 down to 8
// RULE7: software changes rate only while stopped
// RULE8: run bit low stops, zeroes the chain
// RULE9: reset clears the run bit
// RULE10: reset clears the interrupt enable
// RULE11: keeps counting and interrupting in wait mode
// RULE12: register inaccessible in wait or stop
// RULE13: runs in stop only with oscillator enabled
// RULE14: otherwise inactive for the whole stop
// RULE15: software stops timebase before sleep to save power
// RULE16: chain clocked by crystal clock, starts on run
// RULE17: fifteen binary stages, eight selectable taps
// RULE18: first event at half period, then full periods
// RULE19: interrupt level while flag and enable set
// RULE20: all controls share one eight-bit register
module periodic_wakeup_timebase (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // crystal clock, sampled
    input wire logic crystal_clock_in,
    // processor power state
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic osc_in_stop_enable_in,
    // interrupt request and chain status
    output logic irq_out,
    output logic chain_active_out
);

    // declarations
    wakeup_timebase_pkg::ctrl_t ctrl_reg;
    wakeup_timebase_pkg::ctrl_t ctrl_next;
    wakeup_timebase_pkg::power_t power;

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    logic active_reg;
    logic active_next;
    logic xtal_prev_reg;
    logic xtal_prev_next;

    logic xtal_tick;
    logic cpu_access_ok;
    logic ctrl_hit;
    logic ctrl_write;
    logic ctrl_read;
    logic ack_write;
    logic chain_active;
    logic rollover;
    logic [7:0] ctrl_image;

    // power state and bus qualification
    assign power.wait_mode = wait_mode_in;
    assign power.stop_mode = stop_mode_in;
    assign power.osc_in_stop_enable = osc_in_stop_enable_in;

    // in stop without the oscillator the chain freezes
    assign chain_active = !power.stop_mode || power.osc_in_stop_enable; // RULE11 RULE13 RULE14

    // the processor cannot reach the register while asleep
    assign cpu_access_ok = !power.wait_mode && !power.stop_mode; // RULE12

    assign ctrl_hit = (reg_addr_in == wakeup_timebase_pkg::CTRL_OFFSET);
    assign ctrl_write = reg_write_in && ctrl_hit && cpu_access_ok;
    assign ctrl_read = reg_read_in && ctrl_hit && cpu_access_ok;

    // only a written one acknowledges; a written zero is no action
    assign ack_write = ctrl_write && reg_wdata_in[wakeup_timebase_pkg::ACK_BIT]; // RULE3 RULE5

    // read image of the control register
    always_comb begin
        ctrl_image = wakeup_timebase_pkg::READ_IDLE;
        ctrl_image[wakeup_timebase_pkg::FLAG_BIT] = ctrl_reg.flag; // RULE20
        ctrl_image[wakeup_timebase_pkg::RATE_LSB +: wakeup_timebase_pkg::RATE_W] = ctrl_reg.rate;
        ctrl_image[wakeup_timebase_pkg::IRQ_EN_BIT] = ctrl_reg.irq_en;
        ctrl_image[wakeup_timebase_pkg::RUN_BIT] = ctrl_reg.run;
        ctrl_image[wakeup_timebase_pkg::ACK_BIT] = 1'b0; // RULE4
    end

    // crystal edge detection
    always_comb begin
        xtal_prev_next = crystal_clock_in;
    end

    assign xtal_tick = crystal_clock_in && !xtal_prev_reg; // RULE16

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_prev_next;
        end
    end

    // divider chain
    timebase_divider_chain u_chain (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .run_in(ctrl_reg.run),
        .active_in(chain_active),
        .xtal_tick_in(xtal_tick),
        .rate_in(ctrl_reg.rate),
        .rollover_out(rollover)
    );

    // control register
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_write) begin
            ctrl_next.run = reg_wdata_in[wakeup_timebase_pkg::RUN_BIT];
            ctrl_next.irq_en = reg_wdata_in[wakeup_timebase_pkg::IRQ_EN_BIT];
            // rate follows the write even while running; software is
            // expected to stop the chain first
            ctrl_next.rate =
                reg_wdata_in[wakeup_timebase_pkg::RATE_LSB +: wakeup_timebase_pkg::RATE_W]; // RULE7
        end
        // the flag bit itself is not writable
        if (ack_write) begin
            ctrl_next.flag = 1'b0; // RULE3
        end
        // a rollover in the acknowledge cycle is kept
        if (rollover) begin
            ctrl_next.flag = 1'b1; // RULE1 RULE11
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_reg <= wakeup_timebase_pkg::CTRL_RESET; // RULE9 RULE10
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // read data: valid only in the cycle after the read strobe
    always_comb begin
        rdata_next = wakeup_timebase_pkg::READ_IDLE;
        if (ctrl_read) begin
            rdata_next = ctrl_image;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_reg <= wakeup_timebase_pkg::READ_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // interrupt request level and status outputs
    always_comb begin
        // computed from next state so the level tracks the flag exactly
        irq_next = ctrl_next.flag && ctrl_next.irq_en; // RULE2 RULE19 RULE13
        active_next = ctrl_next.run && chain_active;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            active_reg <= active_next;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign irq_out = irq_reg;
    assign chain_active_out = active_reg;

endmodule

`default_nettype wire

// ===== core/timebase_divider_chain.sv
// fifteen-stage divider chain with eight selectable rollover taps.
// assumes xtal_tick_in is a one-cycle pulse per crystal clock rising edge.
`timescale 1ns/1ps
`default_nettype none

module timebase_divider_chain (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic run_in,
    input wire logic active_in,
    input wire logic xtal_tick_in,
    input wire logic [2:0] rate_in,
    // event
    output logic rollover_out
);

    logic [14:0] chain_reg;
    logic [14:0] chain_next;
    logic rollover_reg;
    logic rollover_next;
    logic [wakeup_timebase_pkg::TAP_COUNT-1:0] tap_rise;

    // rising edge of each tap bit as the chain advances
    genvar gi;
    generate
        for (gi = 0; gi < wakeup_timebase_pkg::TAP_COUNT; gi = gi + 1) begin : g_tap
            localparam int TB = int'(wakeup_timebase_pkg::TAP_BIT[gi]);
            assign tap_rise[gi] = ~chain_reg[TB] & chain_next[TB];
        end
    endgenerate

    always_comb begin
        chain_next = chain_reg;
        if (!run_in) begin
            chain_next = wakeup_timebase_pkg::CHAIN_ZERO; // RULE8
        end else if (active_in && xtal_tick_in) begin
            chain_next = chain_reg + wakeup_timebase_pkg::CHAIN_ONE; // RULE16 RULE17
        end
        rollover_next = run_in && active_in && xtal_tick_in && tap_rise[rate_in]; // RULE6 RULE18
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            chain_reg <= wakeup_timebase_pkg::CHAIN_ZERO;
            rollover_reg <= 1'b0;
        end else begin
            chain_reg <= chain_next;
            rollover_reg <= rollover_next;
        end
    end

    assign rollover_out = rollover_reg;

endmodule

`default_nettype wire

// ===== core/wakeup_timebase_pkg.sv
// package for the periodic wakeup timebase: register map, field layout,
// reset values and divider tap positions.
// assumes a single 10 MHz system clock and a slower crystal clock input.
package wakeup_timebase_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // single control register
    localparam logic [3:0] CTRL_OFFSET = 4'h0;

    // field positions inside the control register
    localparam int FLAG_BIT = 7;
    localparam int RATE_LSB = 4;
    localparam int RATE_W = 3;
    localparam int ACK_BIT = 3;
    localparam int IRQ_EN_BIT = 2;
    localparam int RUN_BIT = 1;

    // reset values
    localparam logic RUN_RESET = 1'b0;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // divider chain
    localparam int CHAIN_W = 15;
    localparam logic [14:0] CHAIN_ZERO = 15'h0000;
    localparam logic [14:0] CHAIN_ONE = 15'h0001;
    localparam int TAP_COUNT = 8;

    // timing: the crystal is nominally 32768 Hz, the system clock 10 MHz
    localparam int CLK_HZ = 10000000;
    localparam int XTAL_HZ = 32768;
    localparam int CLK_PER_XTAL = CLK_HZ / XTAL_HZ;

    // tap bit of the chain per rate code; divider 2**(tap+1), first event
    // at half that, later ones each full period
    typedef logic [3:0] tap_index_t;
    localparam tap_index_t TAP_BIT [TAP_COUNT] = '{
        4'hE,  // 000: 32768
        4'hC,  // 001: 8192
        4'hA,  // 010: 2048
        4'h6,  // 011: 128
        4'h5,  // 100: 64
        4'h4,  // 101: 32
        4'h3,  // 110: 16
        4'h2   // 111: 8
    };

    // software-visible control state
    typedef struct packed {
        logic run;
        logic irq_en;
        logic [2:0] rate;
        logic flag;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{
        run: RUN_RESET,
        irq_en: IRQ_EN_RESET,
        rate: RATE_RESET,
        flag: FLAG_RESET
    };

    // processor power state seen by the block
    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic osc_in_stop_enable;
    } power_t;

endpackage

// ===== testbench/testbench.sv
// testbench for the periodic wakeup timebase: register tasks, rates, power modes.
// assumes the crystal model toggles every system clock cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 1'b0, srst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, rd;
    logic reg_write_in = 1'b0, reg_read_in = 1'b0, crystal_clock_in, irq_out, chain_active_out;
    logic wait_mode_in = 1'b0, stop_mode_in = 1'b0, osc_in_stop_enable_in = 1'b0;
    logic xtal_prev = 1'b0;
    int ticks = 0, base, n, bad_count = 0, n_checks = 0;
    int divs [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    always #50 clk_in = ~clk_in;
    periodic_wakeup_timebase dut (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
        .reg_read_in, .reg_rdata_out, .crystal_clock_in, .wait_mode_in, .stop_mode_in,
        .osc_in_stop_enable_in, .irq_out, .chain_active_out);
    xtal_source xtal (.clk_in(clk_in), .crystal_out(crystal_clock_in));
    // crystal rising edges as the design samples them
    always @(negedge clk_in) begin
        if (crystal_clock_in && !xtal_prev) ticks <= ticks + 1;
        xtal_prev <= crystal_clock_in;
    end
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value at %0t: %0d ticks, expected %0d", $time, got, exp);
        end
    endtask
    // crystal ticks from base until the interrupt request is seen
    task automatic wait_irq(input int limit);
        for (int i = 0; i < limit; i++) begin
            @(negedge clk_in);
            if (irq_out === 1'b1) break;
        end
        // read before this edge's tick update lands: that edge came after the flag
        n = ticks - base;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_in);
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        reg_read(4'h0, rd);
        check_byte(rd, 8'h00);
        reg_write(4'h5, 8'hFF);
        reg_read(4'h5, rd);
        check_byte(rd, 8'h00);
        check_byte({6'h0, chain_active_out, irq_out}, 8'h00);
        $display("test reset done");
        for (int r = 7; r >= 0; r--) begin
            reg_write(4'h0, 8'h08);
            reg_write(4'h0, {1'b0, 3'(r), 4'h6});
            base = ticks;
            wait_irq(divs[r] + 20);
            check_count(n, divs[r] / 2);
        end
        $display("test rates done");
        reg_write(4'h0, 8'h08);
        reg_write(4'h0, 8'h76);
        base = ticks;
        wait_irq(40);
        reg_read(4'h0, rd);
        check_byte(rd, 8'hF6);
        reg_write(4'h0, 8'h76);
        @(negedge clk_in);
        check_byte({7'h0, irq_out}, 8'h01);
        reg_write(4'h0, 8'h7E);
        @(negedge clk_in);
        @(negedge clk_in);
        check_byte({7'h0, irq_out}, 8'h00);
        wait_irq(40);
        check_count(n, 12);
        reg_write(4'h0, 8'h7A);
        repeat (20) @(negedge clk_in);
        check_byte({7'h0, irq_out}, 8'h00);
        reg_read(4'h0, rd);
        check_byte(rd, 8'hF2);
        $display("test flag done");
        reg_write(4'h0, 8'h7E);
        wait_mode_in <= 1'b1;
        wait_irq(40);
        check_byte({7'h0, irq_out}, 8'h01);
        reg_write(4'h0, 8'h08);
        reg_read(4'h0, rd);
        check_byte(rd, 8'h00);
        check_byte({7'h0, chain_active_out}, 8'h01);
        @(posedge clk_in);
        wait_mode_in <= 1'b0;
        $display("test wait done");
        reg_write(4'h0, 8'h08);
        reg_write(4'h0, 8'h76);
        stop_mode_in <= 1'b1;
        repeat (40) @(negedge clk_in);
        check_byte({6'h0, chain_active_out, irq_out}, 8'h00);
        @(posedge clk_in);
        osc_in_stop_enable_in <= 1'b1;
        wait_irq(60);
        check_byte({6'h0, chain_active_out, irq_out}, 8'h03);
        @(posedge clk_in);
        stop_mode_in <= 1'b0;
        $display("test stop done");
        // reset in mid-run while running with a pending request
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        reg_read(4'h0, rd);
        check_byte(rd, 8'h00);
        check_byte({6'h0, chain_active_out, irq_out}, 8'h00);
        $display("test mid reset done");
        complete_run();
    end
endmodule
bind periodic_wakeup_timebase timebase_sva chk (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .wait_mode_in, .stop_mode_in,
    .osc_in_stop_enable_in, .irq_out, .chain_active_out);
`default_nettype wire

// ===== testbench/timebase_sva.sv
// checker for the timebase ports: read data, interrupt level, chain status.
// assumes it is bound to periodic_wakeup_timebase, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module timebase_sva (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // power state and outputs
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic osc_in_stop_enable_in,
    input wire logic irq_out,
    input wire logic chain_active_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic awake;
    logic refused_read;
    assign awake = !wait_mode_in && !stop_mode_in;
    assign refused_read = reg_read_in && (!awake || reg_addr_in != 4'h0);
    sequence ctrl_write;
        reg_write_in && reg_addr_in == 4'h0 && awake;
    endsequence
    sequence run_on_write;
        ctrl_write ##0 reg_wdata_in[wakeup_timebase_pkg::RUN_BIT] ##1 !stop_mode_in;
    endsequence
    a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    a_ack_reads_zero: assert property (reg_rdata_out[3] == 1'b0)
        else $error("acknowledge bit read as one");
    a_refused_read: assert property ($past(refused_read) |-> reg_rdata_out == 8'h00)
        else $error("refused read returned data");
    a_reset_clears: assert property ($fell(srst_in) |-> !irq_out && !chain_active_out)
        else $error("outputs active after reset");
    a_run_starts: assert property (run_on_write |-> ##[0:1] chain_active_out)
        else $error("chain not active after run");
    a_run_stops: assert property (ctrl_write ##0 !reg_wdata_in[1] |-> ##[1:2] !chain_active_out)
        else $error("chain active after stop");
    a_ie_clear_drops: assert property (ctrl_write ##0 !reg_wdata_in[2] |-> ##[1:2] !irq_out)
        else $error("irq with enable cleared");
    a_stop_freezes: assert property (stop_mode_in && !osc_in_stop_enable_in |=> !chain_active_out)
        else $error("chain active in stop");
    a_wait_keeps: assert property (chain_active_out && wait_mode_in && $past(wait_mode_in)
        && !stop_mode_in |=> chain_active_out)
        else $error("chain halted in wait");
endmodule
`default_nettype wire

// ===== testbench/xtal_source.sv
// crystal oscillator model: free-running square wave.
// assumes clk_in is the system clock; half period counted in its cycles.
`timescale 1ns/1ps
`default_nettype none
module xtal_source #(
    parameter int HALF_CYCLES = 1
) (
    // clock
    input wire logic clk_in,
    // crystal output
    output logic crystal_out
);
    int phase = 0;
    initial crystal_out = 1'b0;
    // never stops, as a real oscillator would not
    always @(posedge clk_in) begin
        if (phase == HALF_CYCLES - 1) begin
            phase <= 0;
            crystal_out <= ~crystal_out;
        end else begin
            phase <= phase + 1;
        end
    end
endmodule
`default_nettype wire
